// [uurm_pkg.sv]
// constants, register map and field layout of the upper register bank
// Function
// R1 - addresses 0x00 through 0x19 decode, twenty-six locations
// R2 - 0x07, 0x08, 0x0B-0x0D, 0x17 unused; twenty registers remain
// R3 - each register has its own byte depth; transfers must match it
// R4 - writes are staged; applied on update strobe or profile change
// R5 - fields numbered msb to lsb, bit 0 lsb, groups read as words
// R6 - quadrature: bits 63:58 rate, 57 spectral invert, 56 bypass
// R7 - address 0x00 is the first control function register
// R8 - mode 00 quadrature, 01 single tone, 1x interpolating converter
// R9 - single tone: 14-bit amplitude, 16-bit phase, 32-bit frequency
package uurm_pkg;
	localparam int NUM_ADDR = 26;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 64;
	localparam int NBYTE_W = 4;
	localparam int PROF_W = 3;

	localparam logic [ADDR_W-1:0] A_CTRL_ONE = 5'h00;
	localparam logic [ADDR_W-1:0] A_PROF0 = 5'h0E;
	localparam logic [ADDR_W-1:0] A_PROF7 = 5'h15;
	localparam logic [ADDR_W-1:0] A_RAM = 5'h16;
	localparam logic [ADDR_W-1:0] A_PIN_DIR = 5'h18;
	localparam logic [ADDR_W-1:0] A_PIN_VAL = 5'h19;
	localparam logic [ADDR_W-1:0] A_LAST = 5'h19;
	localparam logic [ADDR_W-1:0] A_GAP0_LO = 5'h07;
	localparam logic [ADDR_W-1:0] A_GAP0_HI = 5'h08;
	localparam logic [ADDR_W-1:0] A_GAP1_LO = 5'h0B;
	localparam logic [ADDR_W-1:0] A_GAP1_HI = 5'h0D;
	localparam logic [ADDR_W-1:0] A_GAP2 = 5'h17;

	localparam logic [NBYTE_W-1:0] DEPTH_NONE = 4'h0;
	localparam logic [NBYTE_W-1:0] DEPTH_CTRL = 4'h4;
	localparam logic [NBYTE_W-1:0] DEPTH_PROF = 4'h8;
	localparam logic [NBYTE_W-1:0] DEPTH_RAM = 4'h4;
	localparam logic [NBYTE_W-1:0] DEPTH_PIN = 4'h2;

	localparam logic [DATA_W-1:0] RESET_VAL = 64'h0;

	localparam int MODE_HI = 25;
	localparam int MODE_LO = 24;
	localparam logic [1:0] MODE_QUAD = 2'h0;
	localparam logic [1:0] MODE_TONE = 2'h1;
	localparam int MODE_INTERP_BIT = 1;

	localparam int ASF_HI = 61;
	localparam int ASF_LO = 48;
	localparam int POW_HI = 47;
	localparam int POW_LO = 32;
	localparam int FTW_HI = 31;
	localparam int FTW_LO = 0;
	localparam int RATE_HI = 63;
	localparam int RATE_LO = 58;
	localparam int SPINV_BIT = 57;
	localparam int INV_COMB_BYP_BIT = 56;
	localparam int OSF_HI = 55;
	localparam int OSF_LO = 48;

	// byte depth per location; zero marks an unused location
	function automatic logic [NBYTE_W-1:0] uurm_depth(
		input logic [ADDR_W-1:0] a);
		logic [NBYTE_W-1:0] d;
		d = DEPTH_CTRL;
		if (a > A_LAST)
			d = DEPTH_NONE;
		else if (a == A_GAP0_LO || a == A_GAP0_HI || a == A_GAP2)
			d = DEPTH_NONE;
		else if (a >= A_GAP1_LO && a <= A_GAP1_HI)
			d = DEPTH_NONE;
		else if (a >= A_PROF0 && a <= A_PROF7)
			d = DEPTH_PROF;
		else if (a == A_RAM)
			d = DEPTH_RAM;
		else if (a == A_PIN_DIR || a == A_PIN_VAL)
			d = DEPTH_PIN;
		return d;
	endfunction
endpackage

// [uurm_sync_if.sv]
// carrier between the pin conditioner and the register bank
`timescale 1ns/1ps
interface uurm_sync_if;
	import uurm_pkg::*;
	logic [PROF_W-1:0] profile;
	logic apply;
	modport src (output profile, output apply);
	modport dst (input profile, input apply);
endinterface

// [uurm_pin_sync.sv]
// pin conditioner: synchronises update strobe and profile pins
`timescale 1ns/1ps
module uurm_pin_sync
	import uurm_pkg::*;
#(
	parameter int SYNC_W = PROF_W + 1
) (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic io_update_pin, // update strobe pin
	input wire logic [PROF_W-1:0] profile_pin, // profile select pins
	uurm_sync_if.src sy // conditioned profile and apply pulse
);
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] s1_reg;
	logic [SYNC_W-1:0] s2_reg;
	logic [SYNC_W-1:0] s3_reg;
	logic [SYNC_W-1:0] lvl_reg;
	logic [SYNC_W-1:0] prev_reg;
	logic apply_reg;

	generate
		if (SYNC_W != PROF_W + 1) begin : g_bad
			$error("uurm_pin_sync: SYNC_W must be PROF_W + 1");
		end
	endgenerate

	assign raw = {io_update_pin, profile_pin};

	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
					lvl_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= raw[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					// a change only counts once stages two and three agree
					if (s2_reg[i] == s3_reg[i])
						lvl_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_reg <= '0;
			apply_reg <= 1'b0;
		end else begin
			prev_reg <= lvl_reg;
			// rising update edge or any profile change [R4]
			apply_reg <= (lvl_reg[PROF_W] & ~prev_reg[PROF_W]) |
				(lvl_reg[PROF_W-1:0] != prev_reg[PROF_W-1:0]);
		end
	end

	assign sy.profile = lvl_reg[PROF_W-1:0];
	assign sy.apply = apply_reg;
endmodule

// [uurm_bank.sv]
// staged register bank with active copies and profile field decode
`timescale 1ns/1ps
module uurm_bank
	import uurm_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic wr_stb, // write request, one cycle
	input wire logic [ADDR_W-1:0] wr_addr, // write address
	input wire logic [NBYTE_W-1:0] wr_nbytes, // bytes carried
	input wire logic [DATA_W-1:0] wr_data, // right-aligned data
	output logic wr_err, // write refused, one-cycle pulse
	input wire logic [ADDR_W-1:0] rd_addr, // read address
	output logic [DATA_W-1:0] rd_data, // staged value, one cycle late
	output logic [NBYTE_W-1:0] rd_depth, // depth of rd_addr, registered
	input wire logic io_update_pin, // update strobe pin
	input wire logic [PROF_W-1:0] profile_pin, // profile select pins
	output logic [1:0] op_mode, // active operating mode
	output logic mode_quad, // quadrature modulation selected
	output logic mode_tone, // single tone selected
	output logic mode_interp, // interpolating converter selected
	output logic [31:0] ctrl_one, // active first control register
	output logic [13:0] tone_amp, // selected profile amplitude
	output logic [15:0] prof_phase, // selected profile phase offset
	output logic [31:0] prof_freq, // selected profile tuning word
	output logic [5:0] comb_rate_hi, // interpolation rate upper bits
	output logic spec_invert, // spectral inversion
	output logic inv_comb_bypass, // inverse comb-integrator bypass
	output logic [7:0] out_scale, // quadrature output scale
	output logic [31:0] ram_word, // active playback memory word
	output logic [15:0] pin_dir, // active pin direction word
	output logic [15:0] pin_val // active pin value word
);
	uurm_sync_if sy ();

	uurm_pin_sync u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.io_update_pin(io_update_pin),
		.profile_pin(profile_pin),
		.sy(sy)
	);

	logic [DATA_W-1:0] stage_reg [NUM_ADDR];
	logic [DATA_W-1:0] act_reg [NUM_ADDR];
	logic [NBYTE_W-1:0] wr_depth;
	logic wr_ok;
	logic [DATA_W-1:0] wr_mask;
	logic [DATA_W-1:0] sel_prof;
	logic [1:0] mode_next;

	assign wr_depth = uurm_depth(wr_addr); // [R1] [R2]
	// the transfer must carry exactly the register's depth [R3]
	assign wr_ok = wr_stb && (wr_depth != DEPTH_NONE) &&
		(wr_nbytes == wr_depth);

	// bits above the register's depth never reach storage [R5]
	always_comb begin
		wr_mask = '0;
		for (int b = 0; b < DATA_W / 8; b++)
			if (b < int'(wr_depth))
				wr_mask[b*8 +: 8] = 8'hFF;
	end

	genvar i;
	generate
		for (i = 0; i < NUM_ADDR; i++) begin : g_reg
			if (uurm_depth(ADDR_W'(i)) == DEPTH_NONE) begin : g_unused
				assign stage_reg[i] = RESET_VAL; // [R2]
				assign act_reg[i] = RESET_VAL;
			end else begin : g_used
				always_ff @(posedge sys_clk or negedge rstn) begin
					if (!rstn)
						stage_reg[i] <= RESET_VAL;
					else if (wr_ok && wr_addr == ADDR_W'(i))
						stage_reg[i] <= wr_data & wr_mask;
				end
				// an apply in the same cycle as a write copies the
				// older staged value; the new one waits for the next
				always_ff @(posedge sys_clk or negedge rstn) begin
					if (!rstn)
						act_reg[i] <= RESET_VAL;
					else if (sy.apply)
						act_reg[i] <= stage_reg[i]; // [R4]
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			wr_err <= 1'b0;
		else
			wr_err <= wr_stb && !wr_ok; // [R2] [R3]
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= RESET_VAL;
			rd_depth <= DEPTH_NONE;
		end else if (uurm_depth(rd_addr) == DEPTH_NONE) begin
			rd_data <= RESET_VAL; // [R1] [R2]
			rd_depth <= DEPTH_NONE;
		end else begin
			rd_data <= stage_reg[rd_addr];
			rd_depth <= uurm_depth(rd_addr); // [R3]
		end
	end

	// the profile pins pick which of the eight profile words is decoded
	assign sel_prof = act_reg[A_PROF0 + ADDR_W'(sy.profile)];
	assign mode_next = act_reg[A_CTRL_ONE][MODE_HI:MODE_LO]; // [R7] [R8]

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			op_mode <= MODE_QUAD;
			mode_quad <= 1'b1;
			mode_tone <= 1'b0;
			mode_interp <= 1'b0;
			ctrl_one <= '0;
		end else begin
			op_mode <= mode_next;
			mode_quad <= (mode_next == MODE_QUAD); // [R8]
			mode_tone <= (mode_next == MODE_TONE);
			mode_interp <= mode_next[MODE_INTERP_BIT];
			ctrl_one <= act_reg[A_CTRL_ONE][31:0]; // [R7]
		end
	end

	// fields always decode from the word; the mode flags say which apply
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tone_amp <= '0;
			prof_phase <= '0;
			prof_freq <= '0;
			comb_rate_hi <= '0;
			spec_invert <= 1'b0;
			inv_comb_bypass <= 1'b0;
			out_scale <= '0;
		end else begin
			tone_amp <= sel_prof[ASF_HI:ASF_LO]; // [R9]
			prof_phase <= sel_prof[POW_HI:POW_LO]; // [R9] [R5]
			prof_freq <= sel_prof[FTW_HI:FTW_LO]; // [R9]
			comb_rate_hi <= sel_prof[RATE_HI:RATE_LO]; // [R6]
			spec_invert <= sel_prof[SPINV_BIT]; // [R6]
			inv_comb_bypass <= sel_prof[INV_COMB_BYP_BIT]; // [R6]
			out_scale <= sel_prof[OSF_HI:OSF_LO];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ram_word <= '0;
			pin_dir <= '0;
			pin_val <= '0;
		end else begin
			ram_word <= act_reg[A_RAM][31:0];
			pin_dir <= act_reg[A_PIN_DIR][15:0];
			pin_val <= act_reg[A_PIN_VAL][15:0];
		end
	end
endmodule

// [uurm_host_model.sv]
// host model: drives the write and read port of the bank
`timescale 1ns/1ps
module uurm_host_model
	import uurm_pkg::*;
(
	input wire logic sys_clk, // system clock
	output logic wr_stb, // write request
	output logic [ADDR_W-1:0] wr_addr, // write address
	output logic [NBYTE_W-1:0] wr_nbytes, // byte count
	output logic [DATA_W-1:0] wr_data, // write data
	input wire logic wr_err, // refusal pulse
	output logic [ADDR_W-1:0] rd_addr, // read address
	input wire logic [DATA_W-1:0] rd_data // staged value
);
	initial begin
		wr_stb = 1'b0;
		wr_addr = 5'h00;
		wr_nbytes = 4'h0;
		wr_data = 64'h0;
		rd_addr = 5'h00;
	end
	task automatic wr(input logic [4:0] a, input logic [3:0] n,
		input logic [63:0] d, output logic e);
		@(posedge sys_clk);
		wr_stb <= 1'b1;
		wr_addr <= a;
		wr_nbytes <= n;
		wr_data <= d;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		// released data turns over so a stale value cannot pass
		wr_data <= ~d;
		#1 e = wr_err;
	endtask
	task automatic rd(input logic [4:0] a, output logic [63:0] d);
		@(posedge sys_clk);
		rd_addr <= a;
		@(posedge sys_clk);
		#1 d = rd_data;
	endtask
endmodule

// [uurm_bank_checker.sv]
// assertions on the upper register bank ports
`timescale 1ns/1ps
module uurm_bank_checker
	import uurm_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, active low
	input wire logic wr_stb, // write request
	input wire logic [ADDR_W-1:0] wr_addr, // write address
	input wire logic [NBYTE_W-1:0] wr_nbytes, // byte count
	input wire logic [DATA_W-1:0] wr_data, // write data
	input wire logic wr_err, // refusal pulse
	input wire logic [ADDR_W-1:0] rd_addr, // read address
	input wire logic [DATA_W-1:0] rd_data, // staged value
	input wire logic [NBYTE_W-1:0] rd_depth, // read depth
	input wire logic io_update_pin, // update pin
	input wire logic [PROF_W-1:0] profile_pin, // profile pins
	input wire logic [1:0] op_mode, // active mode
	input wire logic mode_quad, // quadrature flag
	input wire logic mode_tone, // single tone flag
	input wire logic mode_interp, // interpolating flag
	input wire logic [31:0] ctrl_one, // control word
	input wire logic [13:0] tone_amp, // amplitude
	input wire logic [5:0] comb_rate_hi, // rate upper bits
	input wire logic [7:0] out_scale, // output scale
	input wire logic [15:0] pin_val // pin value word
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_quiet;
		(!io_update_pin && $stable(profile_pin))[*8];
	endsequence
	// full-depth profile writes need no mask, so the word compares whole
	sequence s_prof_wr;
		wr_stb && wr_nbytes == 4'h8 && uurm_depth(wr_addr) == 4'h8;
	endsequence
	sequence s_read_back;
		rd_addr == $past(wr_addr);
	endsequence
	property p_stage;
		s_prof_wr ##1 s_read_back |=> rd_data == $past(wr_data, 2);
	endproperty
	property p_err_bad;
		wr_stb && wr_nbytes != uurm_depth(wr_addr) |=> wr_err;
	endproperty
	property p_ok;
		wr_stb && wr_nbytes == uurm_depth(wr_addr) && wr_nbytes != 4'h0
			|=> !wr_err;
	endproperty
	property p_range;
		rd_addr > 5'h19 |=> rd_depth == 4'h0;
	endproperty
	property p_rd_unused;
		uurm_depth(rd_addr) == 4'h0 |=> rd_data == 64'h0;
	endproperty
	property p_hold;
		s_quiet |=> $stable(pin_val);
	endproperty
	property p_mode;
		mode_quad == (op_mode == 2'h0) && mode_tone == (op_mode == 2'h1)
			&& mode_interp == op_mode[1];
	endproperty
	property p_ctrl;
		op_mode == ctrl_one[25:24];
	endproperty
	property p_overlap;
		tone_amp[13:10] == comb_rate_hi[3:0] && out_scale == tone_amp[7:0];
	endproperty
	a_err_bad: assert property (p_err_bad)
		else $error("bad write not refused");
	a_ok: assert property (p_ok)
		else $error("good write refused");
	a_range: assert property (p_range)
		else $error("depth beyond map");
	a_rd_unused: assert property (p_rd_unused)
		else $error("unused read nonzero");
	a_hold: assert property (p_hold)
		else $error("pin word moved without apply");
	a_mode: assert property (p_mode)
		else $error("mode flags wrong");
	a_ctrl: assert property (p_ctrl)
		else $error("mode not from control word");
	a_overlap: assert property (p_overlap)
		else $error("profile fields misplaced");
	a_stage: assert property (p_stage)
		else $error("staged profile word not read back");
endmodule
bind uurm_bank uurm_bank_checker i_chk (.*);

// [test_upconverter_upper_register_map.sv]
// testbench of the upper register bank
`timescale 1ns/1ps
module test_upconverter_upper_register_map;
	import uurm_pkg::*;
	localparam logic [63:0] PW = 64'hFDCB_1234_89AB_CDEF;
	logic sys_clk, rstn, wr_stb, wr_err, io_update_pin, e;
	logic mode_quad, mode_tone, mode_interp, spec_invert, inv_comb_bypass;
	logic [63:0] wr_data, rd_data, d;
	logic [31:0] ctrl_one, prof_freq, ram_word;
	logic [15:0] prof_phase, pin_dir, pin_val;
	logic [13:0] tone_amp;
	logic [7:0] out_scale;
	logic [5:0] comb_rate_hi;
	logic [4:0] wr_addr, rd_addr;
	logic [3:0] wr_nbytes, rd_depth;
	logic [2:0] profile_pin;
	logic [1:0] op_mode;
	int failures = 0;
	int check_count = 0;
	uurm_bank i_dut (.*);
	uurm_host_model i_host (.*);
	function automatic logic [3:0] dep(input logic [4:0] a);
		if (a > 5'h19 || a == 5'h07 || a == 5'h08 || a == 5'h17)
			return 4'h0;
		if (a >= 5'h0B && a <= 5'h0D)
			return 4'h0;
		if (a >= 5'h0E && a <= 5'h15)
			return 4'h8;
		return (a >= 5'h18) ? 4'h2 : 4'h4;
	endfunction
	task automatic chk(input string n, input logic [63:0] x, y);
		check_count++;
		if (x !== y) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// no completion flag exists, so wait out the pin path plus margin
	task automatic apply;
		@(posedge sys_clk);
		io_update_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		io_update_pin <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 1'b0;
		io_update_pin = 1'b0;
		profile_pin = 3'h0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		chk("quad", 1'b1, mode_quad);
		for (int a = 0; a < 32; a++) begin
			i_host.rd(a[4:0], d);
			chk("depth", dep(a[4:0]), rd_depth);
		end
		i_host.wr(5'h18, 4'h4, 64'h1111, e);
		chk("err_count", 1'b1, e);
		i_host.wr(5'h17, 4'h4, 64'h2222, e);
		chk("err_unused", 1'b1, e);
		i_host.rd(5'h17, d);
		chk("unused", 64'h0, d);
		i_host.wr(5'h19, 4'h2, 64'hA5C3, e);
		chk("err_ok", 1'b0, e);
		i_host.rd(5'h19, d);
		chk("staged", 64'hA5C3, d);
		i_host.rd(5'h18, d);
		chk("refused", 64'h0, d);
		chk("pin_hold", 16'h0, pin_val);
		apply();
		chk("pin_val", 16'hA5C3, pin_val);
		// upper bits beyond the four-byte depth must be dropped
		i_host.wr(5'h16, 4'h4, 64'hFFFF_FFFF_1357_9BDF, e);
		chk("err_ram", 1'b0, e);
		i_host.rd(5'h16, d);
		chk("ram_mask", 64'h0000_0000_1357_9BDF, d);
		i_host.wr(5'h18, 4'h2, 64'h0000_0000_0000_C35A, e);
		chk("ram_hold", 32'h0, ram_word);
		i_host.rd(5'h15, d);
		chk("prof_empty", 64'h0, d);
		i_host.wr(5'h15, 4'h8, PW, e);
		i_host.rd(5'h15, d);
		chk("prof_staged", PW, d);
		chk("dir_hold", 16'h0, pin_dir);
		@(posedge sys_clk);
		profile_pin <= 3'h7;
		repeat (10) @(posedge sys_clk);
		chk("amp", PW[61:48], tone_amp);
		chk("phase", PW[47:32], prof_phase);
		chk("freq", PW[31:0], prof_freq);
		chk("rate", PW[63:58], comb_rate_hi);
		chk("inv", PW[57:56], {spec_invert, inv_comb_bypass});
		chk("scale", PW[55:48], out_scale);
		chk("ram", 32'h1357_9BDF, ram_word);
		chk("pin_dir", 16'hC35A, pin_dir);
		chk("pin_keep", 16'hA5C3, pin_val);
		for (int m = 0; m < 4; m++) begin
			i_host.wr(5'h00, 4'h4, {38'h0, m[1:0], 24'h0}, e);
			apply();
			chk("ctrl", {m[1:0], 24'h0}, ctrl_one);
			chk("mode", {m == 0, m == 1, m[1], m[1:0]},
				{mode_quad, mode_tone, mode_interp, op_mode});
		end
		report_and_stop();
	end
endmodule
